// ===== design/pcrc_pkg.sv
package pcrc_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned PCRC_NPERIPH  = 26;
  localparam int unsigned PCRC_NPRESENT = 32;
  localparam int unsigned PCRC_AW       = 8;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] PCRC_OFF_RUN_EN    = 8'h00;
  localparam logic [7:0] PCRC_OFF_SLP_EN    = 8'h04;
  localparam logic [7:0] PCRC_OFF_SRST      = 8'h08;
  localparam logic [7:0] PCRC_OFF_GATING    = 8'h0c;
  localparam logic [7:0] PCRC_OFF_PRESENT   = 8'h10;
  localparam logic [7:0] PCRC_OFF_ACTIVE    = 8'h14;
  localparam logic [7:0] PCRC_OFF_IRQ_STAT  = 8'h18;
  localparam logic [7:0] PCRC_OFF_IRQ_MASK  = 8'h1c;
  localparam logic [7:0] PCRC_OFF_GLOBAL_ST = 8'h20;

  // ==========================================================================
  // fields and reset values
  localparam int unsigned PCRC_BIT_GATING    = 0;
  localparam int unsigned PCRC_BIT_IRQ_FAULT = 0;
  localparam int unsigned PCRC_BIT_IRQ_WAKE  = 1;
  localparam int unsigned PCRC_NIRQ          = 2;
  localparam logic [25:0] PCRC_RUN_RST       = 26'h0;
  localparam logic [25:0] PCRC_SLP_RST       = 26'h0;
  // default presence pattern: all 26 peripherals present, set per device by the parameter
  localparam logic [31:0] PCRC_PRESENT_DFLT  = 32'h03ff_ffff;

  // ==========================================================================
  // timing
  localparam int unsigned PCRC_EN_LAT_CYC  = 5;
  localparam int unsigned PCRC_RST_PULSE   = 4;
  localparam int unsigned PCRC_CNT_W       = 3;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [25:0] clk_en;
    logic [25:0] rst_n;
  } pcrc_periph_t;

  typedef struct packed {
    logic [25:0] access;
    logic [25:0] wake;
  } pcrc_periph_in_t;

endpackage

// ===== design/pcrc_latency.sv
`timescale 1ns/100ps
// per-peripheral enable latency and reset pulse timer
module pcrc_latency
  import pcrc_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic run_en,
  input  wire logic srst_req,
  // status
  output logic      active,
  output logic      in_window,
  output logic      rst_n
);

  logic [PCRC_CNT_W-1:0] lat_reg;
  logic [PCRC_CNT_W-1:0] pulse_reg;

  // =========================================================================
  // enable latency: count five cycles after the enable write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_reg <= '0;
      active  <= 1'b0;
    end else if (!run_en) begin
      lat_reg <= '0;
      active  <= 1'b0;
    end else if (!active) begin
      if (lat_reg == PCRC_CNT_W'(PCRC_EN_LAT_CYC - 1)) begin
        active <= 1'b1;
      end else begin
        lat_reg <= lat_reg + 1'b1;
      end
    end
  end

  assign in_window = run_en && !active;

  // =========================================================================
  // reset pulse, self-releasing; run enable left untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= '0;
    end else if (srst_req) begin
      pulse_reg <= PCRC_CNT_W'(PCRC_RST_PULSE);
    end else if (pulse_reg != '0) begin
      pulse_reg <= pulse_reg - 1'b1;
    end
  end

  assign rst_n = (pulse_reg == '0);

endmodule

// ===== design/pcrc_gate.sv
`timescale 1ns/100ps
// sleep-mode clock gating decision for one peripheral
module pcrc_gate (
  // inputs
  input  wire logic active,
  input  wire logic slp_en,
  input  wire logic gating_on,
  input  wire logic sleeping,
  // output
  output logic      clk_en
);

  // sleep enable only matters with the global switch on
  always_comb begin
    if (!active) begin
      clk_en = 1'b0;
    end else if (sleeping && gating_on) begin
      clk_en = slp_en;
    end else begin
      clk_en = 1'b1;
    end
  end

endmodule

// ===== design/pcrc_top.sv
`timescale 1ns/100ps
// How it works
// - After reset every run enable is clear and a disabled peripheral is neither clocked nor reachable.
// - A peripheral becomes active five cycles after the write that sets its run enable.
// - An access to a peripheral inside its enable latency answers with a bus fault.
// - A software reset request drives that peripheral's reset low for a short pulse, then releases it.
// - The reset pulse leaves the run enable set, so the peripheral keeps working from reset state.
// - With gating on and sleep enable clear, the peripheral clock stops while the processor sleeps.
// - A run-enabled peripheral stopped in sleep resumes with its state when run mode returns.
// - Sleep enables are kept while gating is off but do not affect clocking until it is on.
// - A peripheral with sleep enable set keeps its clock through sleep.
// - A peripheral clocked in sleep can raise a wake request that returns the processor to run.
// - A read-only presence mask says which peripherals exist in this device.
// - With gating off every peripheral is clocked in sleep as in run mode.
module pcrc_top
  import pcrc_pkg::*;
#(
  parameter logic [31:0] PRESENT_MASK = PCRC_PRESENT_DFLT
)(
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [PCRC_AW-1:0]      paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // processor power state, same clock domain
  input  wire logic                    cpu_sleeping,
  output logic                         wake_req,
  // peripheral side
  input  wire pcrc_periph_in_t         periph_in,
  output pcrc_periph_t                 periph_out,
  output logic                         periph_fault,
  // interrupt
  output logic                         irq
);

  // ==========================================================================
  // registers
  logic [PCRC_NPERIPH-1:0] run_en_reg;
  logic [PCRC_NPERIPH-1:0] slp_en_reg;
  logic                    gating_reg;
  logic [PCRC_NPERIPH-1:0] srst_pulse;
  logic [PCRC_NIRQ-1:0]    irq_stat_reg;
  logic [PCRC_NIRQ-1:0]    irq_mask_reg;
  logic [PCRC_NPERIPH-1:0] active;
  logic [PCRC_NPERIPH-1:0] in_window;
  logic [PCRC_NPERIPH-1:0] rst_n;
  logic [PCRC_NPERIPH-1:0] clk_en;
  logic                    wr_en;
  logic                    rd_en;
  logic [31:0]             rd_mux;
  logic                    rd_err;
  logic                    fault_evt;
  logic                    wake_evt;

  // ==========================================================================
  // apb decode: a write lands only at the edge that completes the transfer,
  // so a held access phase never writes twice (strobes would repeat)
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite;

  // run enables, one bit per peripheral
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en_reg <= PCRC_RUN_RST;
    end else if (wr_en && paddr == PCRC_OFF_RUN_EN) begin
      run_en_reg <= pwdata[PCRC_NPERIPH-1:0] & PRESENT_MASK[PCRC_NPERIPH-1:0];
    end
  end

  // sleep enables, kept whatever the global switch says
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_en_reg <= PCRC_SLP_RST;
    end else if (wr_en && paddr == PCRC_OFF_SLP_EN) begin
      slp_en_reg <= pwdata[PCRC_NPERIPH-1:0];
    end
  end

  // global sleep gating switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gating_reg <= 1'b0;
    end else if (wr_en && paddr == PCRC_OFF_GATING) begin
      gating_reg <= pwdata[PCRC_BIT_GATING];
    end
  end

  // soft reset request: write-one strobe, reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_pulse <= '0;
    end else if (wr_en && paddr == PCRC_OFF_SRST) begin
      srst_pulse <= pwdata[PCRC_NPERIPH-1:0];
    end else begin
      srst_pulse <= '0;
    end
  end

  // ==========================================================================
  // per-peripheral timers and gating
  genvar gi;
  generate
    for (gi = 0; gi < PCRC_NPERIPH; gi++) begin : g_periph
      pcrc_latency u_lat (
        .pclk      (pclk),
        .presetn   (presetn),
        .run_en    (run_en_reg[gi]),
        .srst_req  (srst_pulse[gi]),
        .active    (active[gi]),
        .in_window (in_window[gi]),
        .rst_n     (rst_n[gi])
      );
      pcrc_gate u_gate (
        .active    (active[gi]),
        .slp_en    (slp_en_reg[gi]),
        .gating_on (gating_reg),
        .sleeping  (cpu_sleeping),
        .clk_en    (clk_en[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // peripheral outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_out.clk_en <= '0;
      periph_out.rst_n  <= '0;
    end else begin
      periph_out.clk_en <= clk_en;
      periph_out.rst_n  <= rst_n;
    end
  end

  // access inside the latency window or to a disabled peripheral faults
  assign fault_evt = |(periph_in.access & (in_window | ~active));

  // wake only from a peripheral whose delivered clock is running
  assign wake_evt = cpu_sleeping && |(periph_in.wake & periph_out.clk_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_fault <= 1'b0;
      wake_req     <= 1'b0;
    end else begin
      periph_fault <= fault_evt;
      wake_req     <= wake_evt;
    end
  end

  // ==========================================================================
  // interrupts: sticky, write one to clear, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
    end else begin
      for (int i = 0; i < PCRC_NIRQ; i++) begin
        if ((i == PCRC_BIT_IRQ_FAULT && fault_evt) || (i == PCRC_BIT_IRQ_WAKE && wake_evt)) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr_en && paddr == PCRC_OFF_IRQ_STAT && pwdata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= '0;
    end else if (wr_en && paddr == PCRC_OFF_IRQ_MASK) begin
      irq_mask_reg <= pwdata[PCRC_NIRQ-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================================
  // read mux; unmapped addresses answer with pslverr
  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    unique case (paddr)
      PCRC_OFF_RUN_EN:    rd_mux[PCRC_NPERIPH-1:0] = run_en_reg;
      PCRC_OFF_SLP_EN:    rd_mux[PCRC_NPERIPH-1:0] = slp_en_reg;
      PCRC_OFF_SRST:      rd_mux = '0;
      PCRC_OFF_GATING:    rd_mux[PCRC_BIT_GATING] = gating_reg;
      PCRC_OFF_PRESENT:   rd_mux = PRESENT_MASK;
      PCRC_OFF_ACTIVE:    rd_mux[PCRC_NPERIPH-1:0] = active;
      PCRC_OFF_IRQ_STAT:  rd_mux[PCRC_NIRQ-1:0] = irq_stat_reg;
      PCRC_OFF_IRQ_MASK:  rd_mux[PCRC_NIRQ-1:0] = irq_mask_reg;
      PCRC_OFF_GLOBAL_ST: rd_mux[PCRC_NPERIPH-1:0] = clk_en;
      default:            rd_err = 1'b1;
    endcase
  end

  // registered answer: pready rises the cycle after the access phase begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= rd_en ? rd_mux : '0;
      pslverr <= rd_err;
    end else begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ===== tb/pcrc_monitor.sv
`timescale 1ns/100ps
module pcrc_monitor
  import pcrc_pkg::*;
(
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic               pready,
  input wire logic [PCRC_AW-1:0] paddr,
  input wire logic [31:0]        pwdata,
  // power state and peripherals
  input wire logic               cpu_sleeping,
  input wire logic               wake_req,
  input wire pcrc_periph_in_t    periph_in,
  input wire pcrc_periph_t       periph_out,
  input wire logic               periph_fault
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ========
  // helpers: writes act at the edge where pready is high
  wire wr1  = psel && penable && pready && pwrite && pwdata[0];
  wire en0  = periph_out.clk_en[0];
  wire run0 = wr1 && paddr == PCRC_OFF_RUN_EN && !en0 && !cpu_sleeping;
  wire rst0 = wr1 && paddr == PCRC_OFF_SRST;
  wire acc  = |periph_in.access;
  wire wk   = |(periph_in.wake & periph_out.clk_en);
  // ========
  // assertions
  chk_reset_clear: assert property (!$past(presetn) |-> (periph_out.clk_en == 26'h0) [*3])
    else $error("clock enable set right after reset");
  chk_run_latency: assert property (run0 |=> (!en0) [*6] ##1 en0)
    else $error("enable latency wrong");
  chk_fault_cause: assert property (periph_fault |-> $past(acc))
    else $error("fault without access");
  chk_no_fault: assert property (periph_in.access == 26'h1 && en0 |=> !periph_fault)
    else $error("fault on a running peripheral");
  chk_srst_pulse: assert property (rst0 |-> ##3 (!periph_out.rst_n[0]) [*4] ##1 periph_out.rst_n[0])
    else $error("soft reset pulse wrong");
  chk_srst_keeps: assert property (rst0 && en0 && !cpu_sleeping |=> en0 [*7])
    else $error("soft reset stopped the clock");
  chk_sleep_resume: assert property (en0 ##1 (cpu_sleeping && !psel) [*3] ##1 !cpu_sleeping |=> en0)
    else $error("clock not back after sleep");
  chk_wake_set: assert property (cpu_sleeping && wk |=> wake_req)
    else $error("wake request missed");
  chk_wake_cause: assert property (wake_req |-> $past(cpu_sleeping))
    else $error("wake request while running");
  cov_fault: cover property (acc ##1 periph_fault);
  cov_srst: cover property ($fell(periph_out.rst_n[0]));
  cov_wake: cover property ($rose(wake_req));
endmodule

bind pcrc_top pcrc_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .cpu_sleeping(cpu_sleeping),
  .wake_req(wake_req), .periph_in(periph_in), .periph_out(periph_out), .periph_fault(periph_fault));

// ===== tb/pcrc_periph_model.sv
`timescale 1ns/100ps
module pcrc_periph_model
  import pcrc_pkg::*;
(
  // clock
  input  wire logic        pclk,
  // block side
  input  wire pcrc_periph_t periph_out,
  output pcrc_periph_in_t  periph_in,
  // bench commands
  input  wire logic [25:0] acc_cmd,
  input  wire logic [25:0] wake_cmd,
  output logic [7:0]       cnt0
);
  // ========
  // peripheral 0 state: runs only when clocked, cleared by its own reset
  always_ff @(posedge pclk) begin
    if (!periph_out.rst_n[0])
      cnt0 <= 8'h00;
    else if (periph_out.clk_en[0])
      cnt0 <= cnt0 + 8'h01;
  end
  // a stopped peripheral cannot raise wake; access timing is the bench's duty
  assign periph_in.wake   = wake_cmd & periph_out.clk_en;
  assign periph_in.access = acc_cmd;
endmodule

// ===== tb/pcrc_top_tb.sv
`timescale 1ns/100ps
module pcrc_top_tb
  import pcrc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic cpu_sleeping, wake_req, periph_fault, irq;
  logic [PCRC_AW-1:0] paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [25:0]        acc_cmd, wake_cmd;
  logic [7:0]         cnt0, held;
  pcrc_periph_t       periph_out;
  pcrc_periph_in_t    periph_in;
  int                 n_errors, total_checks;

  pcrc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cpu_sleeping(cpu_sleeping), .wake_req(wake_req), .periph_in(periph_in),
    .periph_out(periph_out), .periph_fault(periph_fault), .irq(irq));
  pcrc_periph_model u_periph (.pclk(pclk), .periph_out(periph_out), .periph_in(periph_in),
    .acc_cmd(acc_cmd), .wake_cmd(wake_cmd), .cnt0(cnt0));

  // 4 ns clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ========
  // tasks
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; an idle cycle follows so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_errors++;
      results();
    end
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poke(input logic [25:0] m);
    acc_cmd <= m;
    cyc(1);
    acc_cmd <= 26'h0;
    cyc(1);
  endtask
  // ========
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, cpu_sleeping} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    acc_cmd = 26'h0;
    wake_cmd = 26'h0;
    cyc(20);
    presetn <= 1'b1;
    cyc(1);
    // reset state, read-only presence, unmapped place
    apb(1'b0, PCRC_OFF_RUN_EN, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, PCRC_OFF_PRESENT, 32'h0);
    apb(1'b0, PCRC_OFF_PRESENT, 32'h0);
    chk(rd, PCRC_PRESENT_DFLT);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, serr}, 32'h1);
    // disabled peripheral faults; irq masked, raised, cleared
    poke(26'h2);
    chk({31'h0, periph_fault}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, PCRC_OFF_IRQ_MASK, 32'h1);
    cyc(1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, PCRC_OFF_IRQ_STAT, 32'h1);
    cyc(1);
    chk({31'h0, irq}, 32'h0);
    // enable 0 and 2 together; touching 0 inside the window faults
    apb(1'b1, PCRC_OFF_RUN_EN, 32'h5);
    poke(26'h1);
    chk({31'h0, periph_fault}, 32'h1);
    cyc(3);
    chk({6'h0, periph_out.clk_en}, 32'h0);
    cyc(1);
    chk({6'h0, periph_out.clk_en}, 32'h5);
    poke(26'h1);
    chk({31'h0, periph_fault}, 32'h0);
    // soft reset of 0 only
    apb(1'b1, PCRC_OFF_SRST, 32'h1);
    cyc(2);
    chk({30'h0, periph_out.rst_n[2], periph_out.rst_n[0]}, 32'h2);
    cyc(4);
    chk({24'h0, cnt0}, 32'h0);
    chk({30'h0, periph_out.rst_n[0], periph_out.clk_en[0]}, 32'h3);
    apb(1'b0, PCRC_OFF_RUN_EN, 32'h0);
    chk(rd, 32'h5);
    // sleep with gating off: sleep enables kept but ignored
    apb(1'b1, PCRC_OFF_SLP_EN, 32'h4);
    cpu_sleeping <= 1'b1;
    cyc(3);
    cpu_sleeping <= 1'b0;
    chk({31'h0, periph_out.clk_en[0]}, 32'h1);
    apb(1'b0, PCRC_OFF_SLP_EN, 32'h0);
    chk(rd, 32'h4);
    // gating on: 0 stops, 2 runs and wakes, 0 resumes with its state
    apb(1'b1, PCRC_OFF_GATING, 32'h1);
    cpu_sleeping <= 1'b1;
    wake_cmd <= 26'h4;
    cyc(2);
    wake_cmd <= 26'h0;
    chk({31'h0, wake_req}, 32'h1);
    cyc(1);
    held = cnt0;
    cpu_sleeping <= 1'b0;
    chk({30'h0, periph_out.clk_en[2], periph_out.clk_en[0]}, 32'h2);
    cyc(2);
    chk({31'h0, periph_out.clk_en[0]}, 32'h1);
    chk({24'h0, cnt0}, {24'h0, held});
    results();
  end
endmodule
